// ==== core/frs_pkg.sv ====
// Constants, field layouts and carriers for the result status flag block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package frs_pkg;

  // Register byte addresses
  localparam logic [7:0] FRS_OFF_RESULT = 8'h00;
  localparam logic [7:0] FRS_OFF_DRIVE  = 8'h04;
  localparam logic [7:0] FRS_OFF_CTRL   = 8'h08;
  localparam logic [7:0] FRS_OFF_PREV   = 8'h0c;

  // Result byte field positions
  localparam int FRS_B_CM = 6;
  localparam int FRS_B_DD = 5;
  localparam int FRS_B_WC = 4;
  localparam int FRS_B_SH = 3;
  localparam int FRS_B_SN = 2;
  localparam int FRS_B_BC = 1;
  localparam int FRS_B_MD = 0;

  // Drive byte field positions
  localparam int FRS_B_FT  = 7;
  localparam int FRS_B_WP  = 6;
  localparam int FRS_B_RDY = 5;
  localparam int FRS_B_T0  = 4;
  localparam int FRS_B_TS  = 3;
  localparam int FRS_B_HD  = 2;
  localparam int FRS_B_US1 = 1;
  localparam int FRS_B_US0 = 0;

  // Previous-byte field positions (no data, missing address mark)
  localparam int FRS_B_ND = 2;
  localparam int FRS_B_MA = 0;

  // Reset values and special codes
  localparam logic [7:0] FRS_RST_BYTE = 8'h00;
  localparam logic [7:0] FRS_CYL_BAD  = 8'hff;

  // Primary address group decode
  localparam logic [9:0] FRS_IO_LO  = 10'h3f1;
  localparam logic [9:0] FRS_IO_HI  = 10'h3f7;
  localparam logic [9:0] FRS_IO_ALT = 10'h1f7;

  // Command kinds; the kind of the running command gates which events set flags
  typedef enum logic [1:0] {
    FRS_IDLE,
    FRS_READ,
    FRS_SCAN,
    FRS_WDEL
  } frs_cmd_e;

  // Events from the sequencer and data path
  typedef struct packed {
    logic       cmd_start;
    frs_cmd_e   cmd_kind;
    logic       deleted_mark;
    logic       data_crc_bad;
    logic       sector_missing;
    logic [7:0] cyl_medium;
    logic [7:0] cyl_id;
    logic       scan_equal;
    logic       scan_none;
    logic       data_mark_missing;
  } frs_evt_s;

  // Drive interface levels
  typedef struct packed {
    logic fault;
    logic wprot;
    logic ready;
    logic track0;
    logic two_side;
  } frs_drv_s;

endpackage : frs_pkg

// ==== core/frs_status.sv ====
// Result status flags and drive-state byte behind an APB slave.
// Assumes events are single-cycle pulses synchronous to CLK.
`timescale 1ns/100ps
module frs_status (
  input  wire logic            CLK,
  input  wire logic            ARST_N,
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [7:0]      PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic                 PREADY,
  output logic [31:0]          PRDATA,
  output logic                 PSLVERR,
  input  wire frs_pkg::frs_evt_s EVT,
  input  wire frs_pkg::frs_drv_s DRV,
  input  wire logic            ADDR_STRAP,
  input  wire logic [9:0]      IO_ADDR,
  output logic                 IO_HIT,
  output logic                 SIDE_SEL,
  output logic                 DRV_SEL_HIGH,
  output logic                 DRV_SEL_LOW
);
  import frs_pkg::*;

  logic [7:0] result_q;
  logic [7:0] prev_q;
  logic [7:0] drive_q;
  logic [2:0] sel_q;
  logic       busy_q;
  frs_cmd_e   kind_q;
  logic       cyl_diff;
  logic       no_data;
  logic       apb_acc;

  ////////////////////////////////////////////////////////////////////////
  // Decode helper used for the error answer only; the read mux decodes with its own case
  function automatic logic frs_mapped(input logic [7:0] a);
    frs_mapped = (a == FRS_OFF_RESULT) || (a == FRS_OFF_DRIVE) ||
                 (a == FRS_OFF_CTRL)   || (a == FRS_OFF_PREV);
  endfunction : frs_mapped

  assign apb_acc  = PSEL && PENABLE;
  assign cyl_diff = EVT.cyl_medium != EVT.cyl_id;
  // Sector lookup failure only counts during read, scan, write-deleted
  assign no_data  = EVT.sector_missing && busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Command tracking; the kind gates which events may set flags
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_q <= 1'b0;
      kind_q <= FRS_IDLE;
    end else if (EVT.cmd_start) begin
      busy_q <= EVT.cmd_kind != FRS_IDLE;
      kind_q <= EVT.cmd_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result byte; a new command clears it, events in that cycle still land
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      result_q <= FRS_RST_BYTE;
    end else begin
      if (EVT.cmd_start) begin
        result_q <= FRS_RST_BYTE;
      end
      if (EVT.deleted_mark && (kind_q == FRS_READ ||
                               kind_q == FRS_SCAN) && busy_q) begin
        result_q[FRS_B_CM] <= 1'b1;
      end
      if (EVT.data_crc_bad && busy_q) begin
        result_q[FRS_B_DD] <= 1'b1;
      end
      if (no_data && cyl_diff) begin
        result_q[FRS_B_WC] <= 1'b1;
      end
      if (no_data && cyl_diff && EVT.cyl_medium == FRS_CYL_BAD) begin
        result_q[FRS_B_BC] <= 1'b1;
      end
      if (EVT.scan_equal && kind_q == FRS_SCAN && busy_q) begin
        result_q[FRS_B_SH] <= 1'b1;
      end
      if (EVT.scan_none && kind_q == FRS_SCAN && busy_q) begin
        result_q[FRS_B_SN] <= 1'b1;
      end
      if (EVT.data_mark_missing && busy_q) begin
        result_q[FRS_B_MD] <= 1'b1;
      end
      result_q[7] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Preceding status byte bits that accompany the result flags
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_q <= FRS_RST_BYTE;
    end else begin
      if (EVT.cmd_start) begin
        prev_q <= FRS_RST_BYTE;
      end
      if (no_data) begin
        prev_q[FRS_B_ND] <= 1'b1;
      end
      if (EVT.data_mark_missing && busy_q) begin
        prev_q[FRS_B_MA] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive and side selects, written by software over the control word
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= 3'h0;
    end else if (apb_acc && PWRITE && PADDR == FRS_OFF_CTRL) begin
      sel_q <= PWDATA[2:0];
    end
  end

  // Live drive levels, one cycle of registering
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drive_q <= FRS_RST_BYTE;
    end else begin
      drive_q[FRS_B_FT]  <= DRV.fault;
      drive_q[FRS_B_WP]  <= DRV.wprot;
      drive_q[FRS_B_RDY] <= DRV.ready;
      drive_q[FRS_B_T0]  <= DRV.track0;
      drive_q[FRS_B_TS]  <= DRV.two_side;
      drive_q[FRS_B_HD]  <= sel_q[2];
      drive_q[FRS_B_US1] <= sel_q[1];
      drive_q[FRS_B_US0] <= sel_q[0];
    end
  end

  // Select pins track the control word; status sees the same flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SIDE_SEL     <= 1'b0;
      DRV_SEL_HIGH <= 1'b0;
      DRV_SEL_LOW  <= 1'b0;
    end else begin
      SIDE_SEL     <= sel_q[2];
      DRV_SEL_HIGH <= sel_q[1];
      DRV_SEL_LOW  <= sel_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host address group decoder, enabled only by the strap
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IO_HIT <= 1'b0;
    end else begin
      IO_HIT <= ADDR_STRAP && ((IO_ADDR >= FRS_IO_LO &&
                IO_ADDR <= FRS_IO_HI) || IO_ADDR == FRS_IO_ALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, data and error registered
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !frs_mapped(PADDR);
      PRDATA  <= 32'h0;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        case (PADDR)
          FRS_OFF_RESULT: PRDATA <= {24'h0, result_q};
          FRS_OFF_DRIVE:  PRDATA <= {24'h0, drive_q};
          FRS_OFF_CTRL:   PRDATA <= {29'h0, sel_q};
          FRS_OFF_PREV:   PRDATA <= {24'h0, prev_q};
          default:        PRDATA <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_top_zero;
    @(posedge CLK) disable iff (!ARST_N) result_q[7] == 1'b0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("result top bit set");

  property p_cm;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.deleted_mark && busy_q && kind_q == FRS_READ
      |=> result_q[FRS_B_CM];
  endproperty
  a_cm: assert property (p_cm)
    else $error("control mark not set");

  property p_dd;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.data_crc_bad && busy_q |=> result_q[FRS_B_DD];
  endproperty
  a_dd: assert property (p_dd)
    else $error("crc flag not set");

  property p_wc;
    @(posedge CLK) disable iff (!ARST_N)
      no_data && cyl_diff |=> result_q[FRS_B_WC] && prev_q[FRS_B_ND];
  endproperty
  a_wc: assert property (p_wc)
    else $error("wrong cylinder not set");

  property p_sn;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.scan_none && busy_q && kind_q == FRS_SCAN
      |=> result_q[FRS_B_SN];
  endproperty
  a_sn: assert property (p_sn)
    else $error("scan not satisfied not set");

  property p_md_ma;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.data_mark_missing && busy_q
      |=> result_q[FRS_B_MD] && prev_q[FRS_B_MA];
  endproperty
  a_md_ma: assert property (p_md_ma)
    else $error("missing mark pair not set");

  property p_ft;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_FT] == $past(DRV.fault);
  endproperty
  a_ft: assert property (p_ft)
    else $error("fault bit stale");

  property p_clear;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.cmd_start && !EVT.deleted_mark && !EVT.data_crc_bad &&
      !EVT.sector_missing && !EVT.scan_equal && !EVT.scan_none &&
      !EVT.data_mark_missing |=> result_q == FRS_RST_BYTE;
  endproperty
  a_clear: assert property (p_clear)
    else $error("result not cleared");

  // Equal hit is only honoured inside a scan
  property p_sh;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.scan_equal && busy_q && kind_q == FRS_SCAN
      |=> result_q[FRS_B_SH];
  endproperty
  a_sh: assert property (p_sh)
    else $error("scan equal hit not set");

  // Bad cylinder always brings wrong cylinder with it
  property p_bc;
    @(posedge CLK) disable iff (!ARST_N)
      no_data && cyl_diff && EVT.cyl_medium == FRS_CYL_BAD
      |=> result_q[FRS_B_BC] && result_q[FRS_B_WC];
  endproperty
  a_bc: assert property (p_bc)
    else $error("bad cylinder not set");

  // Missing data mark lands in bit 0
  property p_md;
    @(posedge CLK) disable iff (!ARST_N)
      EVT.data_mark_missing && busy_q |=> result_q[FRS_B_MD];
  endproperty
  a_md: assert property (p_md)
    else $error("missing data mark not set");

  // No-data condition is reported in the preceding byte
  property p_nd;
    @(posedge CLK) disable iff (!ARST_N)
      no_data |=> prev_q[FRS_B_ND];
  endproperty
  a_nd: assert property (p_nd)
    else $error("no data flag not set");

  // Idle events must leave the result byte alone
  property p_idle_hold;
    @(posedge CLK) disable iff (!ARST_N)
      !busy_q && !EVT.cmd_start |=> result_q == $past(result_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("result changed while idle");

  // Write-deleted never reports a control mark
  property p_cm_wdel;
    @(posedge CLK) disable iff (!ARST_N)
      busy_q && kind_q == FRS_WDEL && !EVT.cmd_start
      |=> !result_q[FRS_B_CM];
  endproperty
  a_cm_wdel: assert property (p_cm_wdel)
    else $error("control mark set in write deleted");

  property p_wp;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_WP] == $past(DRV.wprot);
  endproperty
  a_wp: assert property (p_wp)
    else $error("write protect bit stale");

  property p_rdy;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_RDY] == $past(DRV.ready);
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready bit stale");

  property p_t0;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_T0] == $past(DRV.track0);
  endproperty
  a_t0: assert property (p_t0)
    else $error("track zero bit stale");

  property p_ts;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_TS] == $past(DRV.two_side);
  endproperty
  a_ts: assert property (p_ts)
    else $error("two sided bit stale");

  // Status select bits and select pins come from the same word
  property p_hd;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_HD] == $past(sel_q[2]) && SIDE_SEL == drive_q[2];
  endproperty
  a_hd: assert property (p_hd)
    else $error("side select bit stale");

  property p_us1;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_US1] == $past(sel_q[1]) &&
      DRV_SEL_HIGH == drive_q[1];
  endproperty
  a_us1: assert property (p_us1)
    else $error("upper drive select bit stale");

  property p_us0;
    @(posedge CLK) disable iff (!ARST_N)
      ##1 drive_q[FRS_B_US0] == $past(sel_q[0]) &&
      DRV_SEL_LOW == drive_q[0];
  endproperty
  a_us0: assert property (p_us0)
    else $error("lower drive select bit stale");

  // Decoder answers only with the strap high
  property p_hit;
    @(posedge CLK) disable iff (!ARST_N)
      !ADDR_STRAP |=> !IO_HIT;
  endproperty
  a_hit: assert property (p_hit)
    else $error("decoder hit without strap");

  // Ready is a single-cycle pulse, never two in a row
  property p_pready;
    @(posedge CLK) disable iff (!ARST_N)
      PREADY |=> !PREADY;
  endproperty
  a_pready: assert property (p_pready)
    else $error("ready held too long");

  c_nd: cover property (@(posedge CLK) disable iff (!ARST_N)
    prev_q[FRS_B_ND] && result_q[FRS_B_WC]);
  c_read: cover property (@(posedge CLK) disable iff (!ARST_N)
    apb_acc && !PWRITE && PADDR == FRS_OFF_RESULT ##1 PREADY);
  c_bad: cover property (@(posedge CLK) disable iff (!ARST_N)
    result_q[FRS_B_BC]);
  c_sh: cover property (@(posedge CLK) disable iff (!ARST_N)
    result_q[FRS_B_SH]);

endmodule : frs_status

// ==== tb/frs_drive_model.sv ====
// Floppy drive stand-in presenting its status levels to the controller.
// Assumes the bench chooses the levels; they change only after an edge.
`timescale 1ns/100ps
module frs_drive_model (
  input  wire logic         CLK,
  input  wire logic [4:0]   LEVELS,
  output frs_pkg::frs_drv_s DRV
);
  import frs_pkg::*;
  // Register the levels so they settle like a real drive's lines
  always_ff @(posedge CLK) begin
    DRV <= frs_drv_s'(LEVELS);
  end
endmodule : frs_drive_model

// ==== tb/tb.sv ====
// Self-checking bench for the result status flag block.
// Assumes the APB slave answers with PREADY and reads return bits 7:0.
`timescale 1ns/100ps
module tb;
  import frs_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        strap, io_hit, side, dsh, dsl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0]  io_addr;
  logic [4:0]  lev;
  frs_evt_s    evt, v;
  frs_drv_s    drv;
  logic [32:0] q[$];
  logic [9:0]  adr[6] = '{10'h3f0, 10'h3f1, 10'h3f7, 10'h3f8, 10'h1f7, 10'h1f6};
  int          err_total, check_count, seed;

  frs_status i_dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .EVT(evt),
    .DRV(drv), .ADDR_STRAP(strap), .IO_ADDR(io_addr), .IO_HIT(io_hit),
    .SIDE_SEL(side), .DRV_SEL_HIGH(dsh), .DRV_SEL_LOW(dsl));
  frs_drive_model i_drive (.CLK(clk), .LEVELS(lev), .DRV(drv));

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [32:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // One APB transfer; a read files its expected {slverr, data} first
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      close_out();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start a command, pulse one event, read result and preceding bytes
  task automatic run(input frs_cmd_e k, input frs_evt_s e,
                     input logic [7:0] res, input logic [7:0] prv);
    frs_evt_s s;
    s = '0;
    s.cmd_start = 1'b1;
    s.cmd_kind = k;
    e.cmd_kind = k;
    @(posedge clk);
    evt <= s;
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    apb(1'b0, FRS_OFF_RESULT, 32'h0, {25'h0, res});
    apb(1'b0, FRS_OFF_PREV, 32'h0, {25'h0, prv});
    $display("test done: command %0d result %h", k, res);
  endtask : run

  // Monitor: each read answer is paired with the oldest expectation
  always @(posedge clk) begin
    if (pready === 1'b1 && psel && penable && !pwrite) begin
      if (q.size() == 0) chk("unexpected read", 33'h0, 33'h1);
      else chk("read data", {pslverr, prdata}, q.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 12212;
    {arst_n, psel, penable, pwrite, strap} = '0;
    {paddr, pwdata, io_addr, lev} = '0;
    evt = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, FRS_OFF_RESULT, 32'h0, 33'h0);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    // Random drive levels and selects; writes to the drive byte are dropped
    repeat (4) begin
      r = $random(seed);
      lev <= r[4:0];
      apb(1'b1, FRS_OFF_CTRL, {29'h0, r[7:5]}, '0);
      apb(1'b1, FRS_OFF_DRIVE, 32'hffffffff, '0);
      apb(1'b0, FRS_OFF_DRIVE, 32'h0, {25'h0, r[4:0], r[7:5]});
      chk("selects", {30'h0, side, dsh, dsl}, {30'h0, r[7:5]});
    end
    $display("test done: drive byte");
    // Each run opens a new command, so earlier flags must be gone
    v = '0; v.deleted_mark = 1'b1;
    run(FRS_READ, v, 8'h01 << FRS_B_CM, 8'h00);
    run(FRS_WDEL, v, 8'h00, 8'h00);
    run(FRS_SCAN, v, 8'h01 << FRS_B_CM, 8'h00);
    v = '0; v.data_crc_bad = 1'b1;
    run(FRS_READ, v, 8'h01 << FRS_B_DD, 8'h00);
    v = '0; v.scan_equal = 1'b1;
    run(FRS_SCAN, v, 8'h01 << FRS_B_SH, 8'h00);
    run(FRS_READ, v, 8'h00, 8'h00);
    v = '0; v.scan_none = 1'b1;
    run(FRS_SCAN, v, 8'h01 << FRS_B_SN, 8'h00);
    r = $random(seed);
    v = '0; v.sector_missing = 1'b1; v.cyl_medium = {1'b0, r[6:0]};
    v.cyl_id = {1'b1, r[6:0]};
    run(FRS_READ, v, 8'h01 << FRS_B_WC, 8'h01 << FRS_B_ND);
    v.cyl_medium = FRS_CYL_BAD;
    v.cyl_id[7] = 1'b0;
    run(FRS_SCAN, v, 8'h12, 8'h01 << FRS_B_ND);
    v = '0; v.data_mark_missing = 1'b1;
    run(FRS_READ, v, 8'h01 << FRS_B_MD, 8'h01 << FRS_B_MA);
    // Address decoder, with the strap both ways
    foreach (adr[i]) for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      strap   <= s[0];
      io_addr <= adr[i];
      repeat (2) @(posedge clk);
      chk("io hit", {32'h0, io_hit}, {32'h0, s == 1 &&
          ((adr[i] >= 10'h3f1 && adr[i] <= 10'h3f7) || adr[i] == 10'h1f7)});
    end
    $display("test done: address decode");
    close_out();
  end
endmodule : tb
